// file: logic/dbe_pkg.sv
// Purpose: Constants and carrier types for the debug exception condition unit.
// Assumes: Four breakpoint address registers, 32-bit linear addresses.
// Notes:   Field positions follow the debug control and status register layout.
//
// Overview of operation
// - Every debug condition leaves through one exception on vector 1.
// - Instruction breakpoint and register guard are faults; everything else traps.
// - One exception may carry a fault and a trap with both flag sets.
// - Fetch address equal to a breakpoint with condition 0 reports instruction breakpoint.
// - Instruction breakpoint fault is raised before the instruction may commit.
// - Instruction breakpoint outranks every other exception of that instruction.
// - Data write matching condition 1 breakpoint traps and sets its hit flag.
// - Port read or write matching condition 2 breakpoint traps and sets hit flag.
// - Data read or write matching condition 3 breakpoint traps and sets hit flag.
// - Data and port breakpoint traps are raised only after the instruction retires.
// - Set resume flag hides instruction breakpoint matches.
// - Entry to other fault handlers sets resume flag in the saved image.
// - Entry to trap, hardware or software interrupt handlers leaves it clear.
// - Doubleword return and task switch load resume flag; pops and word return don't.
// - Resume flag hides only instruction breakpoints, nothing else.
// - Retirement clears resume flag except doubleword return or task-switching branch.
// - Exact-match enable flags play no part in data breakpoint matching.
// - Repeated moves and stores may report a data hit one iteration late.
// - Repeated port strings trap after the iteration touching the breakpoint.
// - With register guard on, debug register access faults and sets access flag.
// - Guarded debug register access leaves the register unchanged.
// - Debug handler entry clears the register guard enable.
// - Data match when any accessed byte is in the aligned 1, 2 or 4 byte range.
// - Task switch into a task with trap bit set traps with task-switch flag.
`default_nettype none

package dbe_pkg;

	// =====================================================================
	// Sizes and vector
	localparam int        BP_COUNT       = 4;
	localparam logic[7:0] DBG_VECTOR     = 8'h01;

	// =====================================================================
	// Debug control register fields
	localparam int        CTL_GD_BIT     = 13;
	localparam int        CTL_COND_LSB   = 16;
	localparam int        CTL_LEN_LSB    = 18;
	localparam int        CTL_STRIDE     = 4;
	localparam logic[31:0] CTL_RESET     = 32'h0000_0000;

	// Break condition codes
	localparam logic[1:0] COND_EXEC      = 2'h0;
	localparam logic[1:0] COND_WRITE     = 2'h1;
	localparam logic[1:0] COND_IO        = 2'h2;
	localparam logic[1:0] COND_RDWR      = 2'h3;

	// Break length codes
	localparam logic[1:0] LEN_ONE        = 2'h0;
	localparam logic[1:0] LEN_TWO        = 2'h1;

	// =====================================================================
	// Debug status register fields
	localparam int        STS_BD_BIT     = 13;
	localparam int        STS_BS_BIT     = 14;
	localparam int        STS_BT_BIT     = 15;
	localparam logic[31:0] STS_RESET     = 32'h0000_0000;
	localparam logic[31:0] STS_WR_MASK   = 32'h0000_E00F;

	// =====================================================================
	// Debug register indexes
	localparam logic[2:0] IDX_STATUS     = 3'h6;
	localparam logic[2:0] IDX_CONTROL    = 3'h7;

	// =====================================================================
	// Enumerations
	typedef enum logic [2:0] {
		RK_PLAIN     = 3'h0,
		RK_DOUBLEWORD_INTERRUPT_RETURN     = 3'h1,
		RK_TASK_SW   = 3'h2,
		RK_IRET_WORD = 3'h3,
		RK_FLAGS_POP = 3'h4
	} dbe_retire_kind_type;

	typedef enum logic [1:0] {
		EC_FAULT   = 2'h0,
		EC_TRAP    = 2'h1,
		EC_HW_INT  = 2'h2,
		EC_SW_INT  = 2'h3
	} dbe_entry_class_type;

	// =====================================================================
	// Carriers
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} dbe_insn_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [1:0]  size_m1;
		logic        write;
		logic        io;
	} dbe_access_type;

	typedef struct packed {
		logic                valid;
		dbe_retire_kind_type kind;
		logic                rf_image;
		logic                new_task_trap;
		logic                single_step;
	} dbe_retire_type;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [2:0]  idx;
		logic [31:0] wdata;
	} dbe_dreg_req_type;

	typedef struct packed {
		logic                valid;
		dbe_entry_class_type cls;
	} dbe_entry_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] vector;
		logic       is_fault;
		logic       is_trap;
		logic       saved_rf;
	} dbe_exc_type;

	typedef struct packed {
		dbe_exc_type                   exc;
		logic                          chk_ok;
		logic                          dreg_ack;
		logic [31:0]                   dreg_rdata;
		logic                          entry_rf_valid;
		logic                          entry_rf;
		logic                          rf;
		logic [BP_COUNT-1:0]           pend;
		logic [31:0]                   ctl;
		logic [31:0]                   sts;
		logic [BP_COUNT-1:0][31:0]     bpa;
	} dbe_state_type;

endpackage

`default_nettype wire

// file: logic/dbe_unit.sv
// Purpose: Detects and classifies debug exception conditions, owns the debug registers.
// Assumes: Stream waits for chk_ok or exception before committing an instruction.
// Notes:   Retirement in a cycle is applied before the fetch check of that cycle.
`timescale 1ns/10ps
`default_nettype none

module dbe_unit (
	input  wire logic                     ref_clk,
	input  wire logic                     rst_b,
	input  wire dbe_pkg::dbe_insn_type     insn,
	input  wire dbe_pkg::dbe_access_type   acc,
	input  wire dbe_pkg::dbe_retire_type   retire,
	input  wire dbe_pkg::dbe_dreg_req_type dreg_req,
	input  wire dbe_pkg::dbe_entry_type    entry,
	output var  dbe_pkg::dbe_exc_type      exc,
	output logic                          chk_ok,
	output logic                          dreg_ack,
	output logic [31:0]                   dreg_rdata,
	output logic                          entry_rf_valid,
	output logic                          entry_rf,
	output logic                          resume_suppress_flag,
	output logic [31:0]                   debug_control_reg,
	output logic [31:0]                   debug_status_reg
);

	dbe_pkg::dbe_state_type q;
	dbe_pkg::dbe_state_type n;

	logic [dbe_pkg::BP_COUNT-1:0] ibp_match;
	logic [dbe_pkg::BP_COUNT-1:0] data_hit;

	// =====================================================================
	// Per-breakpoint address match
	genvar gi;
	generate
		for (gi = 0; gi < dbe_pkg::BP_COUNT; gi++) begin : g_bp
			logic        enabled;
			logic [1:0]  cond;
			logic [1:0]  blen;
			logic [31:0] mask;
			logic [31:0] bp_lo;
			logic [31:0] bp_hi;
			logic [31:0] acc_lo;
			logic [32:0] acc_hi;
			logic        overlap;
			logic        kind_ok;

			// Local or global enable; exact-match flags are not looked at
			assign enabled = q.ctl[2*gi] | q.ctl[2*gi+1];
			assign cond    = q.ctl[dbe_pkg::CTL_COND_LSB+dbe_pkg::CTL_STRIDE*gi +: 2];
			assign blen    = q.ctl[dbe_pkg::CTL_LEN_LSB+dbe_pkg::CTL_STRIDE*gi +: 2];

			// Aligned range from the length field
			always_comb begin
				if (blen == dbe_pkg::LEN_ONE) begin
					mask = 32'h0000_0000;
				end else if (blen == dbe_pkg::LEN_TWO) begin
					mask = 32'h0000_0001;
				end else begin
					mask = 32'h0000_0003;
				end
			end
			assign bp_lo   = q.bpa[gi] & ~mask;
			assign bp_hi   = bp_lo | mask;

			// Port addresses are zero extended from 16 bits
			assign acc_lo  = acc.io ? {16'h0000, acc.addr[15:0]} : acc.addr;
			assign acc_hi  = {1'b0, acc_lo} + {31'h0000_0000, acc.size_m1};
			assign overlap = ({1'b0, acc_lo} <= {1'b0, bp_hi}) && ({1'b0, bp_lo} <= acc_hi);

			// Access kind against break condition
			always_comb begin
				unique case (cond)
					dbe_pkg::COND_WRITE: kind_ok = acc.write & ~acc.io;
					dbe_pkg::COND_IO:    kind_ok = acc.io;
					dbe_pkg::COND_RDWR:  kind_ok = ~acc.io;
					default:             kind_ok = 1'b0;
				endcase
			end

			assign data_hit[gi]  = enabled & acc.valid & overlap & kind_ok;
			assign ibp_match[gi] = enabled & insn.valid & (cond == dbe_pkg::COND_EXEC)
			                       & (insn.addr == q.bpa[gi]);
		end
	endgenerate

	// =====================================================================
	// Next-state logic
	always_comb begin
		logic [dbe_pkg::BP_COUNT-1:0] trap_bits;
		logic                         ss_hit;
		logic                         ts_hit;
		logic                         ibp_fault;
		logic                         gd_fault;
		logic                         trap_any;
		logic [dbe_pkg::BP_COUNT-1:0] ibp_hits;

		trap_bits = '0;
		ss_hit    = 1'b0;
		ts_hit    = 1'b0;
		ibp_fault = 1'b0;
		gd_fault  = 1'b0;
		trap_any  = 1'b0;
		ibp_hits  = '0;

		n                = q;
		n.exc            = '0;
		n.chk_ok         = 1'b0;
		n.dreg_ack       = 1'b0;
		n.entry_rf_valid = 1'b0;

		// Data and port hits wait for the instruction to retire
		n.pend = q.pend | data_hit;

		// Retirement: report pending traps, manage the resume flag
		if (retire.valid) begin
			trap_bits = n.pend;
			ss_hit    = retire.single_step;
			ts_hit    = (retire.kind == dbe_pkg::RK_TASK_SW) & retire.new_task_trap;
			trap_any  = (|trap_bits) | ss_hit | ts_hit;
			n.pend    = '0;
			if (retire.kind == dbe_pkg::RK_DOUBLEWORD_INTERRUPT_RETURN || retire.kind == dbe_pkg::RK_TASK_SW) begin
				n.rf = retire.rf_image;
			end else begin
				n.rf = 1'b0;
			end
		end

		// Fetch check; resume flag hides only this kind of match
		if (insn.valid) begin
			ibp_hits  = n.rf ? '0 : ibp_match;
			ibp_fault = |ibp_hits;
			n.chk_ok  = ~ibp_fault;
		end

		// Debug register access, blocked by a breakpoint on the same instruction
		if (dreg_req.valid && !ibp_fault) begin
			if (q.ctl[dbe_pkg::CTL_GD_BIT]) begin
				gd_fault = 1'b1;
			end else begin
				n.dreg_ack = 1'b1;
				if (dreg_req.write) begin
					if (dreg_req.idx == dbe_pkg::IDX_STATUS) begin
						n.sts = dreg_req.wdata & dbe_pkg::STS_WR_MASK;
					end else if (dreg_req.idx == dbe_pkg::IDX_CONTROL) begin
						n.ctl = dreg_req.wdata;
					end else if (dreg_req.idx[2] == 1'b0) begin
						n.bpa[dreg_req.idx[1:0]] = dreg_req.wdata;
					end
				end else begin
					if (dreg_req.idx == dbe_pkg::IDX_STATUS) begin
						n.dreg_rdata = q.sts;
					end else if (dreg_req.idx == dbe_pkg::IDX_CONTROL) begin
						n.dreg_rdata = q.ctl;
					end else if (dreg_req.idx[2] == 1'b0) begin
						n.dreg_rdata = q.bpa[dreg_req.idx[1:0]];
					end else begin
						n.dreg_rdata = 32'h0000_0000;
					end
				end
			end
		end

		// Guarded access also holds back the instruction
		if (gd_fault) begin
			n.chk_ok = 1'b0;
		end

		// Status flags: hardware sets win over a software write
		n.sts[dbe_pkg::BP_COUNT-1:0] = n.sts[dbe_pkg::BP_COUNT-1:0] | trap_bits | ibp_hits;
		if (gd_fault) begin
			n.sts[dbe_pkg::STS_BD_BIT] = 1'b1;
		end
		if (ss_hit) begin
			n.sts[dbe_pkg::STS_BS_BIT] = 1'b1;
		end
		if (ts_hit) begin
			n.sts[dbe_pkg::STS_BT_BIT] = 1'b1;
		end

		// One exception on the debug vector, fault and trap together
		if (ibp_fault || gd_fault || trap_any) begin
			n.exc.valid    = 1'b1;
			n.exc.vector   = dbe_pkg::DBG_VECTOR;
			n.exc.is_fault = ibp_fault | gd_fault;
			n.exc.is_trap  = trap_any;
			n.exc.saved_rf = gd_fault & ~ibp_fault;
			n.ctl[dbe_pkg::CTL_GD_BIT] = 1'b0;
		end

		// Saved resume flag image for handlers entered from elsewhere
		if (entry.valid) begin
			n.entry_rf_valid = 1'b1;
			n.entry_rf       = (entry.cls == dbe_pkg::EC_FAULT);
		end
	end

	// =====================================================================
	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			q     <= '0;
			q.ctl <= dbe_pkg::CTL_RESET;
			q.sts <= dbe_pkg::STS_RESET;
		end else begin
			q <= n;
		end
	end

	// =====================================================================
	// Outputs straight from the state register
	assign exc                  = q.exc;
	assign chk_ok               = q.chk_ok;
	assign dreg_ack             = q.dreg_ack;
	assign dreg_rdata           = q.dreg_rdata;
	assign entry_rf_valid       = q.entry_rf_valid;
	assign entry_rf             = q.entry_rf;
	assign resume_suppress_flag = q.rf;
	assign debug_control_reg    = q.ctl;
	assign debug_status_reg     = q.sts;

endmodule

`default_nettype wire

// file: bench/dbe_unit_assertions.sv
// Purpose: Concurrent checks on the debug unit ports.
// Assumes: One clock, reset asynchronous active low.
// Notes:   Bound to the unit from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module dbe_unit_assertions (
	input wire logic                      ref_clk,
	input wire logic                      rst_b,
	input wire dbe_pkg::dbe_insn_type     insn,
	input wire dbe_pkg::dbe_access_type   acc,
	input wire dbe_pkg::dbe_retire_type   retire,
	input wire dbe_pkg::dbe_dreg_req_type dreg_req,
	input wire dbe_pkg::dbe_entry_type    entry,
	input wire dbe_pkg::dbe_exc_type      exc,
	input wire logic                      chk_ok,
	input wire logic                      dreg_ack,
	input wire logic [31:0]               dreg_rdata,
	input wire logic                      entry_rf_valid,
	input wire logic                      entry_rf,
	input wire logic                      resume_suppress_flag,
	input wire logic [31:0]               debug_control_reg,
	input wire logic [31:0]               debug_status_reg
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// ==========================================
	// Steps of a fetch check and a retirement
	sequence s_fetch; insn.valid; endsequence
	sequence s_answer; chk_ok ^ (exc.valid && exc.is_fault); endsequence
	sequence s_load; retire.valid && retire.kind inside {dbe_pkg::RK_DOUBLEWORD_INTERRUPT_RETURN, dbe_pkg::RK_TASK_SW}; endsequence
	sequence s_plain; retire.valid && !(retire.kind inside {dbe_pkg::RK_DOUBLEWORD_INTERRUPT_RETURN, dbe_pkg::RK_TASK_SW}); endsequence
	chk_vector_one: assert property (exc.valid |-> exc.vector == dbe_pkg::DBG_VECTOR)
		else $error("exception vector wrong");
	chk_fetch_answer: assert property (s_fetch |=> s_answer)
		else $error("fetch check not answered once");
	chk_rf_hides: assert property (insn.valid && resume_suppress_flag && !retire.valid && !dreg_req.valid |=> chk_ok)
		else $error("resume flag did not hide fetch match");
	chk_rf_load: assert property (s_load |=> resume_suppress_flag == $past(retire.rf_image))
		else $error("resume flag not loaded");
	chk_rf_clear: assert property (s_plain |=> !resume_suppress_flag)
		else $error("resume flag not cleared");
	chk_trap_after: assert property (exc.valid && exc.is_trap |-> $past(retire.valid))
		else $error("trap without retirement");
	chk_fault_cause: assert property (exc.valid && exc.is_fault |-> $past(insn.valid || dreg_req.valid))
		else $error("fault without fetch or register access");
	chk_guard_fault: assert property (dreg_req.valid && debug_control_reg[13] && !insn.valid |=>
		exc.valid && exc.is_fault && exc.saved_rf && debug_status_reg[13] && !dreg_ack)
		else $error("guarded access not faulted");
	chk_ibp_no_rf: assert property (exc.valid && exc.is_fault && !$past(dreg_req.valid) |-> !exc.saved_rf)
		else $error("resume image set on breakpoint fault");
	chk_guard_drop: assert property (exc.valid |-> !debug_control_reg[13])
		else $error("guard enable kept on exception");
	chk_entry_rf: assert property (entry.valid |=> entry_rf_valid && entry_rf == ($past(entry.cls) == dbe_pkg::EC_FAULT))
		else $error("entry resume image wrong");
	chk_hit_sticky: assert property (|($past(debug_status_reg[3:0]) & ~debug_status_reg[3:0]) |->
		$past(dreg_req.valid && dreg_req.write && dreg_req.idx == dbe_pkg::IDX_STATUS))
		else $error("hit flag cleared by hardware");
endmodule
`default_nettype wire

// file: bench/dbe_stream_model.sv
// Purpose: Instruction stream and handler model facing the debug unit.
// Assumes: Requests change at falling edges, answers read one cycle on.
// Notes:   Commits an instruction only after the unit allows it.
`timescale 1ns/10ps
`default_nettype none
module dbe_stream_model (
	input  wire logic                      ref_clk,
	input  wire logic                      chk_ok,
	input  wire logic                      dreg_ack,
	input  wire logic [31:0]               dreg_rdata,
	output var  dbe_pkg::dbe_insn_type     insn,
	output var  dbe_pkg::dbe_access_type   acc,
	output var  dbe_pkg::dbe_retire_type   retire,
	output var  dbe_pkg::dbe_dreg_req_type dreg_req,
	output var  dbe_pkg::dbe_entry_type    entry
);
	// One request cycle from a falling edge
	task automatic cyc(input dbe_pkg::dbe_insn_type i, input dbe_pkg::dbe_access_type a,
		input dbe_pkg::dbe_retire_type r, input dbe_pkg::dbe_dreg_req_type d, input dbe_pkg::dbe_entry_type e);
		@(negedge ref_clk);
		insn = i;
		acc = a;
		retire = r;
		dreg_req = d;
		entry = e;
	endtask
	task automatic idle();
		cyc('0, '0, '0, '0, '0);
	endtask
	task automatic commit(input dbe_pkg::dbe_retire_type r);
		cyc('0, '0, r, '0, '0);
		idle();
	endtask
	// Fetch, then commit with accesses only when allowed
	task automatic run(input logic [31:0] a, input dbe_pkg::dbe_access_type ac, input dbe_pkg::dbe_retire_type r);
		cyc('{1'b1, a}, '0, '0, '0, '0);
		idle();
		if (chk_ok === 1'b1) begin
			cyc('0, ac, r, '0, '0);
			idle();
		end
	endtask
	task automatic dreg(input logic w, input logic [2:0] x, input logic [31:0] d, output logic [31:0] v, output logic k);
		cyc('0, '0, '0, '{1'b1, w, x, d}, '0);
		idle();
		v = dreg_rdata;
		k = dreg_ack;
	endtask
	task automatic enter(input dbe_pkg::dbe_entry_class_type c);
		cyc('0, '0, '0, '0, '{1'b1, c});
		idle();
	endtask
	// Quiet at time zero
	initial begin
		insn = '0;
		acc = '0;
		retire = '0;
		dreg_req = '0;
		entry = '0;
	end
endmodule
`default_nettype wire

// file: bench/dbe_unit_tb.sv
// Purpose: Self-checking bench for the debug unit.
// Assumes: Answers one cycle after each request.
// Notes:   Monitor pops the oldest expected answer per result.
`timescale 1ns/10ps
`default_nettype none
module dbe_unit_tb;
	localparam logic [3:0]  OK = 4'h8, FLT = 4'h6, TRP = 4'h5, BOTH = 4'h7;
	localparam logic [31:0] CTL = 32'hF210_0055;
	localparam dbe_pkg::dbe_retire_type PLAIN = '{1'b1, dbe_pkg::RK_PLAIN, 1'b0, 1'b0, 1'b0};
	logic ref_clk, rst_b, chk_ok, dreg_ack, entry_rf_valid, entry_rf, resume_suppress_flag, ak;
	logic [31:0] dreg_rdata, debug_control_reg, debug_status_reg, v;
	dbe_pkg::dbe_insn_type insn;
	dbe_pkg::dbe_access_type acc;
	dbe_pkg::dbe_retire_type retire;
	dbe_pkg::dbe_dreg_req_type dreg_req;
	dbe_pkg::dbe_entry_type entry;
	dbe_pkg::dbe_exc_type exc;
	dbe_pkg::dbe_entry_class_type c;
	dbe_pkg::dbe_access_type tab[8];
	logic [3:0] hit[8], q[$], want;
	logic [31:0] bpa[4];
	int miscompares, comparisons, seed, i;
	dbe_stream_model u_stream (.ref_clk(ref_clk), .chk_ok(chk_ok), .dreg_ack(dreg_ack), .dreg_rdata(dreg_rdata),
		.insn(insn), .acc(acc), .retire(retire), .dreg_req(dreg_req), .entry(entry));
	dbe_unit uut (.ref_clk(ref_clk), .rst_b(rst_b), .insn(insn), .acc(acc), .retire(retire), .dreg_req(dreg_req),
		.entry(entry), .exc(exc), .chk_ok(chk_ok), .dreg_ack(dreg_ack), .dreg_rdata(dreg_rdata),
		.entry_rf_valid(entry_rf_valid), .entry_rf(entry_rf), .resume_suppress_flag(resume_suppress_flag),
		.debug_control_reg(debug_control_reg), .debug_status_reg(debug_status_reg));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ==========================================
	// Compare, verdict and register tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic rd(input logic [2:0] x, input logic [31:0] exp);
		u_stream.dreg(1'b0, x, 32'h0000_0000, v, ak);
		check(v, exp);
		check({31'h0, ak}, 32'h0000_0001);
	endtask
	task automatic wr(input logic [2:0] x, input logic [31:0] d);
		u_stream.dreg(1'b1, x, d, v, ak);
		check({31'h0, ak}, 32'h0000_0001);
	endtask
	task automatic go(input logic [31:0] a, input dbe_pkg::dbe_access_type ac, input dbe_pkg::dbe_retire_type r,
		input logic [3:0] ans, input logic [3:0] tr);
		q.push_back(ans);
		if (tr != 4'h0)
			q.push_back(tr);
		u_stream.run(a, ac, r);
	endtask
	// Result monitor against the expectation queue
	always @(posedge ref_clk) begin
		#1;
		if (chk_ok === 1'b1 || exc.valid === 1'b1) begin
			want = (q.size() > 0) ? q.pop_front() : 4'hF;
			check({chk_ok, exc.valid, exc.is_fault, exc.is_trap}, want);
		end
	end
	initial begin
		#100000;
		miscompares++;
		stop_test();
	end
	initial begin
		seed = 63807;
		miscompares = 0;
		comparisons = 0;
		rst_b = 1'b0;
		bpa = '{32'h0000_1000, 32'h000A_0002, 32'h0000_0060, 32'h000C_0000};
		tab = '{'{1'b1, 32'h000A_0002, 2'h0, 1'b1, 1'b0}, '{1'b1, 32'h000A_0002, 2'h0, 1'b0, 1'b0},
			'{1'b1, 32'h000A_0001, 2'h1, 1'b1, 1'b0}, '{1'b1, 32'h0000_0060, 2'h0, 1'b0, 1'b1},
			'{1'b1, 32'h0000_0060, 2'h0, 1'b1, 1'b0}, '{1'b1, 32'h000C_0003, 2'h0, 1'b0, 1'b0},
			'{1'b1, 32'h000C_0004, 2'h3, 1'b1, 1'b0}, '{1'b1, 32'h000B_FFFE, 2'h3, 1'b1, 1'b0}};
		hit = '{4'h2, 4'h0, 4'h2, 4'h4, 4'h0, 4'h8, 4'h0, 4'h8};
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk) rst_b = 1'b1;
		rd(3'h7, 32'h0000_0000);
		rd(3'h6, 32'h0000_0000);
		for (i = 0; i < 4; i++) wr(i[2:0], bpa[i]);
		wr(3'h7, CTL);
		rd(3'h7, CTL);
		go(32'h0000_1000, '0, PLAIN, FLT, 4'h0);
		rd(3'h6, 32'h0000_0001);
		wr(3'h6, 32'h0000_0000);
		for (i = 1; i < 5; i++) begin
			u_stream.commit('{1'b1, dbe_pkg::dbe_retire_kind_type'(i[2:0]), 1'b1, 1'b0, 1'b0});
			check({31'h0, resume_suppress_flag}, {31'h0, i < 3});
		end
		u_stream.commit('{1'b1, dbe_pkg::RK_DOUBLEWORD_INTERRUPT_RETURN, 1'b1, 1'b0, 1'b0});
		go(32'h0000_1000, tab[0], PLAIN, OK, TRP);
		check({31'h0, resume_suppress_flag}, 32'h0000_0000);
		rd(3'h6, 32'h0000_0002);
		wr(3'h6, 32'h0000_0000);
		for (i = 0; i < 8; i++) begin
			go(32'h0000_2000, tab[i], PLAIN, OK, (hit[i] != 4'h0) ? TRP : 4'h0);
			rd(3'h6, {28'h0, hit[i]});
			wr(3'h6, 32'h0000_0000);
		end
		wr(3'h7, CTL & 32'hFFFF_FF00);
		go(32'h0000_1000, tab[0], PLAIN, OK, 4'h0);
		wr(3'h7, CTL);
		q.push_back(BOTH);
		u_stream.cyc('{1'b1, 32'h0000_1000}, '0, '{1'b1, dbe_pkg::RK_PLAIN, 1'b0, 1'b0, 1'b1}, '0, '0);
		u_stream.idle();
		rd(3'h6, 32'h0000_4001);
		wr(3'h6, 32'h0000_0000);
		go(32'h0000_2000, '0, '{1'b1, dbe_pkg::RK_TASK_SW, 1'b0, 1'b1, 1'b0}, OK, TRP);
		rd(3'h6, 32'h0000_8000);
		wr(3'h6, 32'h0000_0000);
		wr(3'h7, CTL | 32'h0000_2000);
		q.push_back(FLT);
		u_stream.dreg(1'b1, 3'h0, 32'h0000_5555, v, ak);
		check({31'h0, ak}, 32'h0000_0000);
		rd(3'h6, 32'h0000_2000);
		rd(3'h7, CTL);
		rd(3'h0, bpa[0]);
		for (i = 0; i < 6; i++) begin
			c = dbe_pkg::dbe_entry_class_type'(2'($random(seed)));
			u_stream.enter(c);
			check({30'h0, entry_rf_valid, entry_rf}, {30'h0, 1'b1, c == dbe_pkg::EC_FAULT});
			go($random(seed) | 32'h0000_0001, '0, PLAIN, OK, 4'h0);
		end
		repeat (3) @(negedge ref_clk);
		check(q.size(), 32'h0000_0000);
		stop_test();
	end
endmodule
bind dbe_unit dbe_unit_assertions u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .insn(insn), .acc(acc), .retire(retire),
	.dreg_req(dreg_req), .entry(entry), .exc(exc), .chk_ok(chk_ok), .dreg_ack(dreg_ack), .dreg_rdata(dreg_rdata),
	.entry_rf_valid(entry_rf_valid), .entry_rf(entry_rf), .resume_suppress_flag(resume_suppress_flag),
	.debug_control_reg(debug_control_reg), .debug_status_reg(debug_status_reg));
`default_nettype wire
